// ---- logic/dph_pkg.sv ----
// Purpose: Shared constants for the packet header host controller
// Assumes: 100 MHz system clock, host-generated link clock
// Notes:   Parity masks list which header data bits feed each parity bit
package dph_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int        CLK_NS      = 10;         // System clock period
   localparam int        LINK_NS     = 80;         // Link clock period
   localparam logic [2:0] PERIOD_CYC =
      3'((LINK_NS / CLK_NS) - 1);                   // Last divider count
   localparam logic [2:0] HALF_CYC   =
      3'(LINK_NS / (2 * CLK_NS));                   // Count of rising edge
   localparam logic [2:0] FALL_CYC   = 3'h0;        // Count of falling edge
   localparam logic [2:0] SAMPLE_CYC = 3'(HALF_CYC + 3'h2); // Rx sample

   ////////////////////////////////////////////////////////////////////////
   // Header layout
   localparam logic [5:0] HDR_BITS   = 6'h20;       // Header bit count
   localparam logic [5:0] HDR_LAST   = 6'h1f;       // Last header bit
   localparam int         VC_LSB     = 6;           // Channel field low bit
   localparam logic [1:0] VC_ZERO    = 2'h0;        // Channel forced for end-of-transmission
   localparam logic [1:0] PAD_BITS   = 2'h0;        // Check bits 7..6

   ////////////////////////////////////////////////////////////////////////
   // Host-to-device packet types
   localparam logic [5:0] DT_END_OF_TX       = 6'h08; // Short
   localparam logic [5:0] DT_WRITE_NOPARAM   = 6'h05; // Short
   localparam logic [5:0] DT_WRITE_ONEPARAM  = 6'h15; // Short
   localparam logic [5:0] DT_READ_NOPARAM    = 6'h06; // Short
   localparam logic [5:0] DT_SET_MAX_RETURN  = 6'h37; // Short
   localparam logic [5:0] DT_LONG_NULL       = 6'h09; // Long
   localparam logic [5:0] DT_LONG_WRITE      = 6'h39; // Long

   // Device-to-host packet types
   localparam logic [5:0] DT_ACK_ERR_REPORT  = 6'h02; // Short
   localparam logic [5:0] DT_LONG_READ_RESP  = 6'h1c; // Long
   localparam logic [5:0] DT_READ_RESP_ONE   = 6'h21; // Short
   localparam logic [5:0] DT_READ_RESP_TWO   = 6'h22; // Short

   ////////////////////////////////////////////////////////////////////////
   // Parity masks over header data bits 23..0
   localparam logic [23:0] PMASK5 = 24'heffc00;
   localparam logic [23:0] PMASK4 = 24'hdf03f0;
   localparam logic [23:0] PMASK3 = 24'hb8e38e;
   localparam logic [23:0] PMASK2 = 24'h749a6d;
   localparam logic [23:0] PMASK1 = 24'hf2555b;
   localparam logic [23:0] PMASK0 = 24'hf12cb7;

   // Transmit state machine
   typedef enum logic [1:0] {
      DPH_TX_IDLE = 2'b00,
      DPH_TX_WAIT = 2'b01,
      DPH_TX_SEND = 2'b10
   } dph_tx_e;

endpackage

// ---- logic/dph_ecc_if.sv ----
// Purpose: Carrier between the controller and a header check unit
// Assumes: Purely combinational check unit
// Notes:   One instance per direction
`timescale 1ns/1ns
interface dph_ecc_if;
   logic [23:0] data;        // Header data bits
   logic [7:0]  rx_check;    // Received check byte
   logic [7:0]  computed;    // Check byte computed from data
   logic [7:0]  syndrome;    // Computed xor received
   logic [23:0] fixed;       // Data after single-bit repair
   logic        single;      // Single bit repaired
   logic        multi;       // Uncorrectable error

   modport user (output data, rx_check,
                 input  computed, syndrome, fixed, single, multi);
   modport calc (input  data, rx_check,
                 output computed, syndrome, fixed, single, multi);
endinterface // dph_ecc_if

// ---- logic/dph_ecc.sv ----
// Purpose: Header check byte generation, syndrome and repair
// Assumes: Inputs stable within the cycle they are used
// Notes:   Single-bit signatures come from the parity mask columns
`timescale 1ns/1ns
module dph_ecc (
   // Check unit side
   dph_ecc_if.calc e
);

   ////////////////////////////////////////////////////////////////////////
   // Check byte generation
   assign e.computed = {dph_pkg::PAD_BITS,
                        ^(e.data & dph_pkg::PMASK5),
                        ^(e.data & dph_pkg::PMASK4),
                        ^(e.data & dph_pkg::PMASK3),
                        ^(e.data & dph_pkg::PMASK2),
                        ^(e.data & dph_pkg::PMASK1),
                        ^(e.data & dph_pkg::PMASK0)};

   // Syndrome of received header
   assign e.syndrome = e.computed ^ e.rx_check;

   ////////////////////////////////////////////////////////////////////////
   // Per-bit signature match and repair
   wire [23:0] hit;          // Syndrome names this bit

   for (genvar i = 0; i < 24; i++) begin : g_bit
      wire [7:0] sig = {dph_pkg::PAD_BITS,
                        dph_pkg::PMASK5[i], dph_pkg::PMASK4[i],
                        dph_pkg::PMASK3[i], dph_pkg::PMASK2[i],
                        dph_pkg::PMASK1[i], dph_pkg::PMASK0[i]};
      assign hit[i] = (e.syndrome == sig);
   end

   // Repair flips the one named bit; a single driver for the whole word
   assign e.fixed = e.data ^ hit;

   // Error classification
   assign e.single = |hit;
   assign e.multi  = (e.syndrome != 8'h00) && !(|hit);

endmodule // dph_ecc

// ---- logic/dph_host.sv ----
// Purpose: Host end of the packet header link: builds and sends headers,
//          receives and checks device headers
// Assumes: Device samples on rising link clock, drives on falling
// Notes:   Payload and footer of long packets are left to other logic
//
// Overview of operation
// - Bytes go bit zero first
// - Multi-byte fields low byte first
// - Every header is exactly four bytes
// - Short: identifier, two data, check byte
// - Long: identifier, length, check byte
// - Channel in bits 7-6, type below
// - End-of-transmission always sent on channel zero
// - One-byte information zeros second byte
// - Length counts payload bytes after header
// - Check covers identifier and two bytes
// - Check bits 7 and 6 zero
// - Parity bits 5 to 3 equations
// - Parity bits 2 to 0 equations
// - Short four bytes, long 6 to 65541
`timescale 1ns/1ns
module dph_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Transmit request
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [1:0]  tx_vc,
   input  wire logic [5:0]  tx_type,
   input  wire logic [7:0]  tx_data0,
   input  wire logic [7:0]  tx_data1,
   // Link pins
   output logic             link_clk,
   output logic             link_frame,
   output logic             link_dout,
   input  wire logic        link_rx_frame,
   input  wire logic        link_din,
   // Received header
   output logic             rx_hdr_valid,
   output logic [1:0]       rx_vc,
   output logic [5:0]       rx_type,
   output logic [7:0]       rx_data0,
   output logic [7:0]       rx_data1,
   output logic [15:0]      rx_word_count,
   output logic             rx_long,
   output logic             rx_single_fixed,
   output logic             rx_multi_err,
   output logic             rx_no_check
);

   ////////////////////////////////////////////////////////////////////////
   // Link clock divider
   logic [2:0] div;          // Position in link clock period

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div <= 3'h0;
      end else begin
         div <= (div == dph_pkg::PERIOD_CYC) ? 3'h0 : div + 3'h1;
      end
   end

   // Clock high in second half; edge and sample points
   assign link_clk = (div >= dph_pkg::HALF_CYC);
   wire   fall_pt  = (div == dph_pkg::FALL_CYC);
   wire   samp_pt  = (div == dph_pkg::SAMPLE_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Transmit header build
   dph_ecc_if tx_e ();       // Transmit check unit carrier
   dph_ecc    u_tx_ecc (.e(tx_e));

   wire is_eot   = (tx_type == dph_pkg::DT_END_OF_TX);
   wire one_byte = (tx_type == dph_pkg::DT_WRITE_NOPARAM) ||
                   (tx_type == dph_pkg::DT_READ_NOPARAM);
   wire [1:0] tx_vc_eff  = is_eot ? dph_pkg::VC_ZERO : tx_vc;
   wire [7:0] tx_d1_eff  = one_byte ? 8'h00 : tx_data1;
   wire [7:0] tx_ident   = {tx_vc_eff, tx_type};
   assign tx_e.data      = {tx_d1_eff, tx_data0, tx_ident};
   assign tx_e.rx_check  = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Transmit sequencer
   dph_pkg::dph_tx_e tx_st;  // Transmit state
   logic [31:0] tx_hdr;      // Held header
   logic [31:0] tx_sh;       // Shift register
   logic [5:0]  tx_bits;     // Bits sent

   assign tx_ready = (tx_st == dph_pkg::DPH_TX_IDLE);
   wire   tx_take  = tx_valid && tx_ready;

   // Load, then one bit per falling link edge, low bit first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_st      <= dph_pkg::DPH_TX_IDLE;
         tx_hdr     <= 32'h0;
         tx_sh      <= 32'h0;
         tx_bits    <= 6'h0;
         link_frame <= 1'b0;
         link_dout  <= 1'b0;
      end else begin
         unique case (tx_st)
            dph_pkg::DPH_TX_IDLE: begin
               if (tx_take) begin
                  // Identifier, data, check byte order
                  tx_hdr <= {tx_e.computed,
                             tx_e.data};
                  tx_st  <= dph_pkg::DPH_TX_WAIT;
               end
            end
            dph_pkg::DPH_TX_WAIT: begin
               if (fall_pt) begin
                  link_frame <= 1'b1;
                  link_dout  <= tx_hdr[0];
                  tx_sh      <= tx_hdr >> 1;
                  tx_bits    <= 6'h1;
                  tx_st      <= dph_pkg::DPH_TX_SEND;
               end
            end
            dph_pkg::DPH_TX_SEND: begin
               if (fall_pt) begin
                  if (tx_bits == dph_pkg::HDR_BITS) begin
                     // Header complete
                     link_frame <= 1'b0;
                     link_dout  <= 1'b0;
                     tx_st      <= dph_pkg::DPH_TX_IDLE;
                  end else begin
                     link_dout  <= tx_sh[0];
                     tx_sh      <= tx_sh >> 1;
                     tx_bits    <= tx_bits + 6'h1;
                  end
               end
            end
            default: begin
               tx_st <= dph_pkg::DPH_TX_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive pin synchronisers
   logic [1:0] din_q;        // Data synchroniser
   logic [1:0] frm_q;        // Frame synchroniser

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         din_q <= 2'b00;
         frm_q <= 2'b00;
      end else begin
         din_q <= {din_q[0], link_din};
         frm_q <= {frm_q[0], link_rx_frame};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive shifter; bits past the header are not taken
   logic [31:0] rx_sh;       // Received header bits
   logic [5:0]  rx_bits;     // Bits received this frame
   logic        rx_done;     // Header complete pulse

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_sh   <= 32'h0;
         rx_bits <= 6'h0;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!frm_q[1]) begin
            rx_bits <= 6'h0;
         end else if (samp_pt && rx_bits != dph_pkg::HDR_BITS) begin
            rx_sh   <= {din_q[1], rx_sh[31:1]};
            rx_bits <= rx_bits + 6'h1;
            rx_done <= (rx_bits == dph_pkg::HDR_LAST);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive check and decode
   dph_ecc_if rx_e ();       // Receive check unit carrier
   dph_ecc    u_rx_ecc (.e(rx_e));

   assign rx_e.data     = rx_sh[23:0];
   assign rx_e.rx_check = rx_sh[31:24];

   wire [5:0] rx_dt    = rx_e.fixed[5:0];
   wire       dt_short = (rx_dt == dph_pkg::DT_ACK_ERR_REPORT) ||
                         (rx_dt == dph_pkg::DT_READ_RESP_ONE) ||
                         (rx_dt == dph_pkg::DT_READ_RESP_TWO);
   wire       dt_long  = (rx_dt == dph_pkg::DT_LONG_READ_RESP);
   wire       dt_known = dt_short || dt_long;

   // Decoded header presented the cycle after completion
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_hdr_valid    <= 1'b0;
         rx_vc           <= 2'h0;
         rx_type         <= 6'h0;
         rx_data0        <= 8'h0;
         rx_data1        <= 8'h0;
         rx_word_count   <= 16'h0;
         rx_long         <= 1'b0;
         rx_single_fixed <= 1'b0;
         rx_multi_err    <= 1'b0;
         rx_no_check     <= 1'b0;
      end else begin
         rx_hdr_valid <= rx_done && dt_known;
         if (rx_done && dt_known) begin
            rx_vc           <= rx_e.fixed[7:dph_pkg::VC_LSB];
            rx_type         <= rx_dt;
            rx_data0        <= rx_e.fixed[15:8];
            rx_data1        <= rx_e.fixed[23:16];
            rx_word_count   <= rx_e.fixed[23:8];
            rx_long         <= dt_long;
            rx_single_fixed <= rx_e.single;
            rx_multi_err    <= rx_e.multi;
            rx_no_check     <= (rx_e.rx_check == 8'h00);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_frame_on;
      $rose(link_frame);
   endsequence

   sequence s_frame_span;
      ##255 link_frame ##1 !link_frame;
   endsequence

   property p_frame_len;
      @(posedge clk) disable iff (!rstn)
      s_frame_on |-> s_frame_span;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("header frame not 32 link bits");

   property p_first_bit;
      @(posedge clk) disable iff (!rstn)
      s_frame_on |-> (link_dout == tx_hdr[0]) ##8 (link_dout == tx_hdr[1]);
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("bit order wrong on link");

   property p_eot_vc;
      @(posedge clk) disable iff (!rstn)
      tx_take && is_eot |=> tx_hdr[7:6] == dph_pkg::VC_ZERO;
   endproperty
   a_eot_vc: assert property (p_eot_vc)
      else $error("end packet sent off channel zero");

   property p_pad_zero;
      @(posedge clk) disable iff (!rstn)
      link_frame |-> tx_hdr[31:30] == dph_pkg::PAD_BITS;
   endproperty
   a_pad_zero: assert property (p_pad_zero)
      else $error("check byte top bits not zero");

   property p_one_byte;
      @(posedge clk) disable iff (!rstn)
      tx_take && one_byte |=> tx_hdr[23:16] == 8'h00;
   endproperty
   a_one_byte: assert property (p_one_byte)
      else $error("second data byte not zero");

   property p_present;
      @(posedge clk) disable iff (!rstn)
      rx_done |=> (rx_hdr_valid == $past(dt_known));
   endproperty
   a_present: assert property (p_present)
      else $error("decoded header strobe late or wrong");

   property p_known_only;
      @(posedge clk) disable iff (!rstn)
      rx_hdr_valid |-> (rx_type == dph_pkg::DT_ACK_ERR_REPORT) ||
         (rx_type == dph_pkg::DT_LONG_READ_RESP) ||
         (rx_type == dph_pkg::DT_READ_RESP_ONE) ||
         (rx_type == dph_pkg::DT_READ_RESP_TWO);
   endproperty
   a_known_only: assert property (p_known_only)
      else $error("unknown type presented");

   property p_clean;
      @(posedge clk) disable iff (!rstn)
      rx_done && rx_e.syndrome == 8'h00 && dt_known |=>
         !rx_single_fixed && !rx_multi_err;
   endproperty
   a_clean: assert property (p_clean)
      else $error("error flagged on clean header");

   property p_flags_excl;
      @(posedge clk) disable iff (!rstn)
      rx_hdr_valid |-> !(rx_single_fixed && rx_multi_err);
   endproperty
   a_flags_excl: assert property (p_flags_excl)
      else $error("single and multi both set");

endmodule // dph_host

// ---- dv/dph_dev_model.sv ----
// Purpose: Behavioural display-side end of the header link
// Assumes: Host makes the link clock; device drives after its fall
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/1ns
module dph_dev_model (
   // Link pins
   input  wire logic link_clk,
   input  wire logic link_frame,
   input  wire logic link_dout,
   output logic      link_rx_frame,
   output logic      link_din
);
   logic [31:0] got_hdr = 32'h0; // Last header taken from the host
   int          got_cnt = 0;     // Headers taken so far
   int          bit_cnt = 0;     // Bits of the current header

   ////////////////////////////////////////
   // Check byte over the 24 header data bits
   function automatic logic [7:0] ecc(input logic [23:0] d);
      ecc = {2'h0,
             ^(d & 24'heffc00), ^(d & 24'hdf03f0),
             ^(d & 24'hb8e38e), ^(d & 24'h749a6d),
             ^(d & 24'hf2555b), ^(d & 24'hf12cb7)};
   endfunction

   // Line idle at time zero
   initial begin
      link_rx_frame = 1'b0;
      link_din      = 1'b0;
   end

   ////////////////////////////////////////
   // Shift host bits in, bit zero first
   always @(posedge link_clk) begin
      if (link_frame === 1'b1) begin
         got_hdr = {link_dout, got_hdr[31:1]};
         bit_cnt = bit_cnt + 1;
         if (bit_cnt == 32) begin
            got_cnt = got_cnt + 1;
         end
      end else begin
         bit_cnt = 0;
      end
   end

   ////////////////////////////////////////
   // Send one header after a gap of link periods
   task automatic send_hdr(input logic [31:0] h, input int gap);
      repeat (gap) @(negedge link_clk);
      for (int i = 0; i < 32; i++) begin
         @(negedge link_clk);
         #1;
         link_rx_frame = 1'b1;
         link_din      = h[i];
      end
      @(negedge link_clk);
      #1;
      link_rx_frame = 1'b0;
      link_din      = ~link_din;
   endtask
endmodule // dph_dev_model

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the header link host end
// Assumes: Free-running link clock from the host
// Notes:   Each scenario but the reset check is one task that judges its own outcome
`timescale 1ns/1ns
module tb;
   logic        clk;             // System clock
   logic        rstn;            // Reset, active low
   logic        tx_valid;        // Send request
   logic [1:0]  tx_vc;           // Send channel
   logic [5:0]  tx_type;         // Send type
   logic [7:0]  tx_data0;        // Send first byte
   logic [7:0]  tx_data1;        // Send second byte
   logic        tx_ready;        // Host idle
   logic        link_clk;        // Link clock
   logic        link_frame;      // Host frame
   logic        link_dout;       // Host data
   logic        link_rx_frame;   // Device frame
   logic        link_din;        // Device data
   logic        rx_hdr_valid;    // Header strobe
   logic [1:0]  rx_vc;           // Received channel
   logic [5:0]  rx_type;         // Received type
   logic [7:0]  rx_data0;        // Received first byte
   logic [7:0]  rx_data1;        // Received second byte
   logic [15:0] rx_word_count;   // Received length
   logic        rx_long;         // Long reply
   logic        rx_single_fixed; // Repaired
   logic        rx_multi_err;    // Uncorrectable
   logic        rx_no_check;     // Zero check byte
   int          fail_count = 0;  // Mismatches
   int          checked = 0;     // Comparisons

   dph_host dut_u (
      .clk(clk), .rstn(rstn), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_vc(tx_vc), .tx_type(tx_type), .tx_data0(tx_data0),
      .tx_data1(tx_data1), .link_clk(link_clk), .link_frame(link_frame),
      .link_dout(link_dout), .link_rx_frame(link_rx_frame),
      .link_din(link_din), .rx_hdr_valid(rx_hdr_valid), .rx_vc(rx_vc),
      .rx_type(rx_type), .rx_data0(rx_data0), .rx_data1(rx_data1),
      .rx_word_count(rx_word_count), .rx_long(rx_long),
      .rx_single_fixed(rx_single_fixed), .rx_multi_err(rx_multi_err),
      .rx_no_check(rx_no_check));

   dph_dev_model m_u (
      .link_clk(link_clk), .link_frame(link_frame), .link_dout(link_dout),
      .link_rx_frame(link_rx_frame), .link_din(link_din));

   ////////////////////////////////////////
   // Compare and count
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic report_and_stop;
      $display("Counts: %0d checked, %0d failed", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole header with its check byte
   function automatic logic [31:0] hdr(input logic [1:0] vc,
      input logic [5:0] ty, input logic [7:0] d0, input logic [7:0] d1);
      hdr = {m_u.ecc({d1, d0, vc, ty}), d1, d0, vc, ty};
   endfunction

   ////////////////////////////////////////
   // One send request, judged at the device side
   task automatic do_tx(input logic [1:0] vc, input logic [5:0] ty,
                        input logic [7:0] d0, input logic [7:0] d1);
      int         n0;
      logic [1:0] ev;
      logic [7:0] e1;
      n0 = m_u.got_cnt;
      ev = (ty == 6'h08) ? 2'h0 : vc;
      e1 = (ty == 6'h05 || ty == 6'h06) ? 8'h00 : d1;
      @(posedge clk);
      tx_valid <= 1'b1;
      tx_vc    <= vc;
      tx_type  <= ty;
      tx_data0 <= d0;
      tx_data1 <= d1;
      do @(posedge clk); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
      @(negedge clk);
      chk("tx_ready", 32'(tx_ready), 32'h0);
      for (int k = 0; k < 400 && m_u.got_cnt == n0; k++) @(negedge clk);
      chk("tx_header", m_u.got_hdr, hdr(ev, ty, d0, e1));
   endtask

   // Every host type, channel forcing and byte zeroing
   task automatic test_tx;
      logic [5:0] ty [7] = '{6'h05, 6'h06, 6'h08, 6'h09, 6'h15, 6'h37,
                             6'h39};
      for (int i = 0; i < 7; i++) begin
         do_tx(2'(i) ^ 2'h1, ty[i], 8'h10 + 8'(i), 8'h81 + 8'(i));
      end
      $display("test_tx done");
   endtask

   ////////////////////////////////////////
   // One device header, strobes counted and fields judged
   task automatic rx_case(input logic [31:0] h, input int gap,
      input int exp_n, input logic [23:0] ed, input logic [1:0] fl);
      int n;
      n = 0;
      fork
         m_u.send_hdr(h, gap);
         for (int k = 0; k < 320 + 8 * gap; k++) begin
            @(negedge clk);
            if (rx_hdr_valid === 1'b1) n++;
         end
      join
      chk("rx_pulses", 32'(n), 32'(exp_n));
      if (exp_n == 1) begin
         chk("rx_fields", {8'h0, rx_data1, rx_data0, rx_vc, rx_type},
             {8'h0, ed});
         chk("rx_flags", 32'({rx_single_fixed, rx_multi_err}),
             32'(fl));
         chk("rx_wc", 32'(rx_word_count), 32'(ed[23:8]));
         chk("rx_long", 32'(rx_long), 32'(ed[5:0] == 6'h1c));
         chk("rx_no_check", 32'(rx_no_check), 32'(h[31:24] == 8'h0));
      end
   endtask

   // Clean replies of every device type, prompt and slow
   task automatic test_rx_good;
      logic [5:0] ty [4] = '{6'h02, 6'h1c, 6'h21, 6'h22};
      for (int i = 0; i < 4; i++) begin
         rx_case(hdr(2'h0, ty[i], 8'h02 + 8'(i), 8'(i % 2)), i % 2, 1,
                 {8'(i % 2), 8'h02 + 8'(i), 2'h0, ty[i]}, 2'b00);
      end
      $display("test_rx_good done");
   endtask

   // Single data flips, a check-bit flip, a double flip, foreign type, absent check byte
   task automatic test_rx_err;
      logic [31:0] h;
      int          pos [4] = '{0, 7, 12, 23};
      h = hdr(2'h0, 6'h22, 8'ha5, 8'h3c);
      for (int i = 0; i < 4; i++) begin
         rx_case(h ^ (32'h1 << pos[i]), 0, 1, h[23:0], 2'b10);
      end
      rx_case(h ^ 32'h1000000, 0, 1, h[23:0], 2'b01);
      rx_case(h ^ 32'h300, 0, 1, h[23:0] ^ 24'h300, 2'b01);
      rx_case(hdr(2'h0, 6'h05, 8'h10, 8'h00), 0, 0, 24'h0, 2'b00);
      rx_case(32'h00000021, 0, 1, 24'h000021, 2'b01);
      $display("test_rx_err done");
   endtask

   ////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      report_and_stop();
   end

   // Main sequence
   initial begin
      rstn     = 1'b0;
      tx_valid = 1'b0;
      tx_vc    = 2'h0;
      tx_type  = 6'h0;
      tx_data0 = 8'h0;
      tx_data1 = 8'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("reset_outputs",
          32'({tx_ready, link_clk, link_frame, rx_hdr_valid}), 32'h8);
      @(posedge clk);
      rstn <= 1'b1;
      $display("test_reset done");
      test_tx();
      test_rx_good();
      test_rx_err();
      report_and_stop();
   end
endmodule // tb
